//--- shared/sbc_pkg.sv
// ----------------------------------------------------------------------------
// constants and types of the serial core
// ----------------------------------------------------------------------------
package sbc_pkg;

    // frame, counter and fifo sizes
    localparam int FRAME_W = 8;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] FRAME_BITS = 4'h8;
    localparam int FIFO_DEPTH = 32;
    // feedback delay in bus clocks
    localparam int FB_STAGES = 2;

    // register byte addresses
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STAT = 8'h04;
    localparam logic [7:0] ADR_DATA = 8'h08;
    localparam logic [7:0] ADR_POLY = 8'h0c;
    localparam logic [7:0] ADR_RXCRC = 8'h10;
    localparam logic [7:0] ADR_TXCRC = 8'h14;
    localparam logic [7:0] ADR_WORD_MASK = 8'hfc;

    // control register fields
    localparam int CTRL_EN = 0;
    localparam int CTRL_MASTER = 1;
    localparam int CTRL_CRC_EN = 2;
    localparam int CTRL_CRC_NEXT = 3;
    localparam int CTRL_DIV_LSB = 8;

    // status register fields
    localparam int STAT_BUSY = 0;
    localparam int STAT_TXE = 1;
    localparam int STAT_RECEIVE_NOT_EMPTY_EVENT = 2;
    localparam int STAT_CRC_ERR = 3;
    localparam int STAT_FULL = 4;
    localparam int STAT_EMPTY = 5;

    // reset values
    localparam logic [7:0] DIV_RST = 8'h04;
    localparam logic [7:0] POLY_RST = 8'h07;
    localparam logic TXE_RST = 1'b1;

    // frame phase, one-hot
    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_SHIFT = 3'b010,
        PH_TAIL = 3'b100
    } sbc_phase_e;

    // wishbone request and answer
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } sbc_wb_req_s;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } sbc_wb_rsp_s;

    // serial link pins
    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic ss_n;
    } sbc_link_in_s;

    typedef struct packed {
        logic sck;
        logic sck_oe;
        logic mosi;
        logic mosi_oe;
        logic miso;
        logic miso_oe;
        logic ss_n;
    } sbc_link_out_s;

    // one step of the running crc, msb first
    function automatic logic [FRAME_W-1:0] crc_step(input logic [FRAME_W-1:0] crc, input logic bit_in,
                                                    input logic [FRAME_W-1:0] poly);
        logic fb;
        fb = crc[FRAME_W-1] ^ bit_in;
        crc_step = {crc[FRAME_W-2:0], 1'b0} ^ (fb ? poly : '0);
    endfunction : crc_step

endpackage : sbc_pkg

//--- src/sbc_core.sv
// Operation
// R1: slave busy falls at every frame end.
// R2: slave software may poll the select line for transaction end.
// R3: receive-not-empty rises as each frame completes.
// R4: transmit-empty rises while the second bit shifts.
// R5: software may wait for busy under a one-frame timeout.
// R6: disable during the last frame lets it finish; busy falls.
// R7: software programs an odd crc polynomial.
// R8: master crc accumulates on the feedback serial clock.
// R9: feedback delay of two bus clocks is tolerated.
// R10: master receive captures every bit through the feedback clock.
// R11: crc accumulates until the crc-next control bit is written.
// R12: with a shared dma channel software moves data by dma.
// R13: bus clock stays within the pad speed limit.
// R14: busy holds from frame start until frame and crc complete.
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// transmit fifo
// ----------------------------------------------------------------------------
module sbc_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // filling side
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    // draining side
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(D);

    // pointers carry one extra wrap bit; depth must be a power of two
    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } sbc_fifo_state_s;

    sbc_fifo_state_s s_reg;
    sbc_fifo_state_s s_next;
    logic [W-1:0] mem [D];
    logic full;
    logic empty;

    // full and empty from the pointers
    assign empty = (s_reg.wr == s_reg.rd);
    assign full = (s_reg.wr[AW] != s_reg.rd[AW]) && (s_reg.wr[AW-1:0] == s_reg.rd[AW-1:0]);
    assign in_ready_o = ~full;
    assign out_valid_o = ~empty;
    assign out_data_o = mem[s_reg.rd[AW-1:0]];

    // pointer advance
    always_comb begin
        s_next = s_reg;
        if (in_valid_i && !full) begin
            s_next.wr = s_reg.wr + 1'b1;
        end
        if (out_ready_i && !empty) begin
            s_next.rd = s_reg.rd + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // storage has no reset; only written words are ever read
    always_ff @(posedge clk_i) begin
        if (in_valid_i && !full) begin
            mem[s_reg.wr[AW-1:0]] <= in_data_i;
        end
    end

endmodule : sbc_fifo

// ----------------------------------------------------------------------------
// serial core with busy, crc and feedback capture
// ----------------------------------------------------------------------------
module sbc_core
    import sbc_pkg::*;
#(
    parameter int TX_DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register bus
    input wire sbc_wb_req_s wb_req_i,
    output sbc_wb_rsp_s wb_rsp_o,
    // serial link
    input wire sbc_link_in_s link_i,
    output sbc_link_out_s link_o
);

    // all state of the core outside the transmit fifo
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic en;
        logic master;
        logic crc_en;
        logic crc_next;
        logic [7:0] div;
        logic [FRAME_W-1:0] poly;
        sbc_phase_e phase;
        logic [7:0] div_cnt;
        logic sck;
        logic sck_oe;
        logic mosi_oe;
        logic miso_oe;
        logic ss_n;
        logic sck_prev;
        logic [FB_STAGES-1:0] fb;
        logic fb_prev;
        logic [CNT_W-1:0] gen_cnt;
        logic [CNT_W-1:0] rx_cnt;
        logic shifted;
        logic crc_phase;
        logic [FRAME_W-1:0] tx_sh;
        logic [FRAME_W-1:0] rx_sh;
        logic [FRAME_W-1:0] rx_data;
        logic busy;
        logic transmit_empty_event;
        logic receive_not_empty_event;
        logic crc_err;
        logic [FRAME_W-1:0] tx_crc;
        logic [FRAME_W-1:0] rx_crc;
    } sbc_state_s;

    sbc_state_s s_reg;
    sbc_state_s s_next;

    logic [7:0] adr_w;
    logic req;
    logic commit;
    logic push;
    logic pop;
    logic tx_in_ready;
    logic tx_valid;
    logic [FRAME_W-1:0] tx_data;
    logic [31:0] rd_mux;
    logic tick;
    logic m_rise;
    logic m_fall;
    logic fall;
    logic cap;
    logic in_bit;
    logic fb_rise;
    logic start_ok;
    logic crc_pend;
    logic [FRAME_W-1:0] rx_new;

    // ------------------------------------------------------------------------
    // transmit buffer
    // ------------------------------------------------------------------------

    // data writes wait for a free slot
    assign adr_w = wb_req_i.adr & ADR_WORD_MASK;
    assign req = wb_req_i.cyc & wb_req_i.stb;
    assign commit = req & s_reg.ack;
    assign push = commit & wb_req_i.we & (adr_w == ADR_DATA) & wb_req_i.sel[0];

    sbc_fifo #(
        .W(FRAME_W),
        .D(TX_DEPTH)
    ) u_tx_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(push),
        .in_data_i(wb_req_i.dat[FRAME_W-1:0]),
        .in_ready_o(tx_in_ready),
        .out_valid_o(tx_valid),
        .out_data_o(tx_data),
        .out_ready_i(pop)
    );

    // ------------------------------------------------------------------------
    // read data selection
    // ------------------------------------------------------------------------

    always_comb begin
        rd_mux = '0;
        unique case (adr_w)
            ADR_CTRL: begin
                rd_mux[CTRL_EN] = s_reg.en;
                rd_mux[CTRL_MASTER] = s_reg.master;
                rd_mux[CTRL_CRC_EN] = s_reg.crc_en;
                rd_mux[CTRL_CRC_NEXT] = s_reg.crc_next;
                rd_mux[CTRL_DIV_LSB +: 8] = s_reg.div;
            end
            ADR_STAT: begin
                rd_mux[STAT_BUSY] = s_reg.busy;
                rd_mux[STAT_TXE] = s_reg.transmit_empty_event;
                rd_mux[STAT_RECEIVE_NOT_EMPTY_EVENT] = s_reg.receive_not_empty_event;
                rd_mux[STAT_CRC_ERR] = s_reg.crc_err;
                rd_mux[STAT_FULL] = ~tx_in_ready;
                rd_mux[STAT_EMPTY] = ~tx_valid;
            end
            ADR_DATA: rd_mux[FRAME_W-1:0] = s_reg.rx_data;
            ADR_POLY: rd_mux[FRAME_W-1:0] = s_reg.poly;
            ADR_RXCRC: rd_mux[FRAME_W-1:0] = s_reg.rx_crc;
            ADR_TXCRC: rd_mux[FRAME_W-1:0] = s_reg.tx_crc;
            default: rd_mux = '0;
        endcase
    end

    // ------------------------------------------------------------------------
    // link edge decoding
    // ------------------------------------------------------------------------

    // master clock divider: half period is div + 1 bus clocks
    assign tick = (s_reg.div_cnt == 8'h00);
    assign m_rise = (s_reg.phase == PH_SHIFT) & tick & ~s_reg.sck & (s_reg.gen_cnt != FRAME_BITS);
    assign m_fall = (s_reg.phase == PH_SHIFT) & tick & s_reg.sck;
    assign fb_rise = s_reg.fb[FB_STAGES-1] & ~s_reg.fb_prev;

    // slave edges from the sampled clock, gated by select
    assign fall = s_reg.master ? m_fall
                : ((s_reg.phase == PH_SHIFT) & ~link_i.sck & s_reg.sck_prev & ~link_i.ss_n);
    // R10 feedback capture
    // master samples on its delayed own clock
    assign cap = s_reg.master ? (fb_rise & (s_reg.phase != PH_IDLE))
               : ((s_reg.phase == PH_SHIFT) & link_i.sck & ~s_reg.sck_prev & ~link_i.ss_n);
    assign in_bit = s_reg.master ? link_i.miso : link_i.mosi;
    assign rx_new = {s_reg.rx_sh[FRAME_W-2:0], in_bit};

    // a slave starts only while selected
    assign start_ok = s_reg.en & (s_reg.master | ~link_i.ss_n);
    assign crc_pend = s_reg.crc_en & s_reg.crc_next;

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------

    always_comb begin
        s_next = s_reg;
        pop = 1'b0;

        // one-cycle answer; data writes stall while full
        s_next.ack = req & ~s_reg.ack & ~(wb_req_i.we & (adr_w == ADR_DATA) & ~tx_in_ready);
        if (s_next.ack) begin
            s_next.rdata = rd_mux;
        end

        // writes land at the ack edge
        if (commit && wb_req_i.we) begin
            unique case (adr_w)
                ADR_CTRL: begin
                    if (wb_req_i.sel[0]) begin
                        s_next.en = wb_req_i.dat[CTRL_EN];
                        s_next.master = wb_req_i.dat[CTRL_MASTER];
                        s_next.crc_en = wb_req_i.dat[CTRL_CRC_EN];
                        // R11 crc runs until told
                        s_next.crc_next = s_reg.crc_next | wb_req_i.dat[CTRL_CRC_NEXT];
                    end
                    if (wb_req_i.sel[1]) begin
                        s_next.div = wb_req_i.dat[CTRL_DIV_LSB +: 8];
                    end
                end
                ADR_STAT: begin
                    if (wb_req_i.sel[0] && wb_req_i.dat[STAT_CRC_ERR]) begin
                        s_next.crc_err = 1'b0;
                    end
                end
                ADR_DATA: s_next.transmit_empty_event = 1'b0;
                ADR_POLY: begin
                    if (wb_req_i.sel[0]) begin
                        s_next.poly = wb_req_i.dat[FRAME_W-1:0];
                    end
                end
                default: ;
            endcase
        end

        // a data read consumes the frame
        if (commit && !wb_req_i.we && adr_w == ADR_DATA) begin
            s_next.receive_not_empty_event = 1'b0;
        end

        // pin samples, feedback delay line
        s_next.sck_prev = link_i.sck;
        // R9 two-clock feedback delay
        s_next.fb = {s_reg.fb[FB_STAGES-2:0], s_reg.sck};
        s_next.fb_prev = s_reg.fb[FB_STAGES-1];

        // frame sequencing
        unique case (s_reg.phase)
            PH_IDLE: begin
                if (start_ok && (crc_pend || tx_valid || !s_reg.master)) begin
                    // R14 busy at frame start
                    s_next.busy = 1'b1;
                    s_next.phase = PH_SHIFT;
                    s_next.ss_n = ~s_reg.master;
                    s_next.div_cnt = s_reg.div;
                    s_next.sck = 1'b0;
                    s_next.gen_cnt = '0;
                    s_next.rx_cnt = '0;
                    s_next.shifted = 1'b0;
                    if (crc_pend) begin
                        // the checksum goes out as one extra frame
                        s_next.tx_sh = s_reg.tx_crc;
                        s_next.crc_phase = 1'b1;
                        s_next.crc_next = 1'b0;
                    end else begin
                        // an empty slave answers zeros
                        s_next.tx_sh = tx_valid ? tx_data : '0;
                        pop = tx_valid;
                    end
                end
            end
            PH_SHIFT: begin
                if (s_reg.master) begin
                    if (tick) begin
                        s_next.div_cnt = s_reg.div;
                        if (m_rise) begin
                            s_next.sck = 1'b1;
                            s_next.gen_cnt = s_reg.gen_cnt + 1'b1;
                        end else if (m_fall) begin
                            s_next.sck = 1'b0;
                            if (s_reg.gen_cnt == FRAME_BITS) begin
                                s_next.phase = PH_TAIL;
                            end
                        end
                    end else begin
                        s_next.div_cnt = s_reg.div_cnt - 1'b1;
                    end
                end else if (link_i.ss_n) begin
                    // deselect abandons the partial frame
                    // R1 slave busy drop
                    s_next.busy = 1'b0;
                    s_next.phase = PH_IDLE;
                    s_next.crc_phase = 1'b0;
                end
            end
            PH_TAIL: ;
        endcase

        // shift out on the falling edge
        if (fall) begin
            s_next.tx_sh = {s_reg.tx_sh[FRAME_W-2:0], 1'b0};
            s_next.shifted = 1'b1;
            if (!s_reg.shifted) begin
                // R4 empty on second bit
                s_next.transmit_empty_event = 1'b1;
            end
        end

        // capture, crc and frame end
        if (cap) begin
            s_next.rx_sh = rx_new;
            s_next.rx_cnt = s_reg.rx_cnt + 1'b1;
            if (s_reg.crc_en && !s_reg.crc_phase) begin
                // R8 crc on feedback
                // a long lag lets the output bit move first
                s_next.rx_crc = crc_step(s_reg.rx_crc, in_bit, s_reg.poly);
                s_next.tx_crc = crc_step(s_reg.tx_crc, s_reg.tx_sh[FRAME_W-1], s_reg.poly);
            end
            if (s_reg.rx_cnt == FRAME_BITS - 1'b1) begin
                // R3 frame complete event
                s_next.rx_data = rx_new;
                s_next.receive_not_empty_event = 1'b1;
                // R1 R6 R14 busy falls at end
                s_next.busy = 1'b0;
                s_next.phase = PH_IDLE;
                s_next.ss_n = 1'b1;
                s_next.sck = 1'b0;
                if (s_reg.crc_phase) begin
                    // check the received checksum
                    if (rx_new != s_reg.rx_crc) begin
                        s_next.crc_err = 1'b1;
                    end
                    s_next.crc_phase = 1'b0;
                    s_next.rx_crc = '0;
                    s_next.tx_crc = '0;
                end
            end
        end

        // a disabled crc restarts from zero
        if (!s_reg.crc_en) begin
            s_next.rx_crc = '0;
            s_next.tx_crc = '0;
        end

        // R6 master sck and mosi drivers stay on through a frame after disable; slave miso driver drops with enable
        s_next.sck_oe = s_reg.master & (s_reg.en | s_next.busy);
        s_next.mosi_oe = s_reg.master & (s_reg.en | s_next.busy);
        s_next.miso_oe = ~s_reg.master & s_reg.en & ~link_i.ss_n;
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg <= '0;
            s_reg.phase <= PH_IDLE;
            s_reg.div <= DIV_RST;
            s_reg.poly <= POLY_RST;
            s_reg.ss_n <= 1'b1;
            s_reg.transmit_empty_event <= TXE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------------
    // outputs from the state register
    // ------------------------------------------------------------------------

    assign wb_rsp_o.ack = s_reg.ack;
    assign wb_rsp_o.dat = s_reg.rdata;
    assign link_o.sck = s_reg.sck;
    assign link_o.sck_oe = s_reg.sck_oe;
    assign link_o.mosi = s_reg.tx_sh[FRAME_W-1];
    assign link_o.mosi_oe = s_reg.mosi_oe;
    assign link_o.miso = s_reg.tx_sh[FRAME_W-1];
    assign link_o.miso_oe = s_reg.miso_oe;
    assign link_o.ss_n = s_reg.ss_n;

endmodule : sbc_core

//--- verification/sbc_core_assertions.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// port checker for the serial core
// ----------------------------------------------------------------------------
module sbc_core_checker
    import sbc_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // watched ports
    input wire sbc_wb_req_s wb_req_i,
    input wire sbc_wb_rsp_s wb_rsp_o,
    input wire sbc_link_in_s link_i,
    input wire sbc_link_out_s link_o
);
    logic rd_req;
    // read awaiting its answer
    assign rd_req = wb_req_i.cyc && wb_req_i.stb && !wb_req_i.we && !wb_rsp_o.ack;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // bus answers
    property p_ack_pulse;
        wb_rsp_o.ack |=> !wb_rsp_o.ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_cause;
        wb_rsp_o.ack |-> $past(wb_req_i.cyc && wb_req_i.stb);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    property p_rd_next;
        rd_req |=> wb_rsp_o.ack;
    endproperty
    a_rd_next: assert property (p_rd_next) else $error("read answer late");
    property p_unmapped;
        rd_req && wb_req_i.adr >= 8'h18 |=> wb_rsp_o.dat == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    // link timing at the reset divider
    property p_frame_min;
        $fell(link_o.ss_n) |-> !link_o.ss_n [*8];
    endproperty
    a_frame_min: assert property (p_frame_min) else $error("frame too short");
    property p_sck_framed;
        $rose(link_o.sck) |-> !link_o.ss_n;
    endproperty
    a_sck_framed: assert property (p_sck_framed) else $error("sck outside frame");
    property p_sck_high;
        $rose(link_o.sck) |-> link_o.sck [*3];
    endproperty
    a_sck_high: assert property (p_sck_high) else $error("sck high too short");
    property p_sck_low;
        $fell(link_o.sck) && !link_o.ss_n |-> !link_o.sck [*5];
    endproperty
    a_sck_low: assert property (p_sck_low) else $error("clock low phase wrong");
    property p_mosi_hold;
        link_o.sck && $past(link_o.sck) && !link_o.ss_n |-> $stable(link_o.mosi);
    endproperty
    a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved");
    // scenarios
    c_frame: cover property ($fell(link_o.ss_n));
    c_write: cover property (wb_rsp_o.ack && wb_req_i.we);
    c_back: cover property ($rose(link_o.ss_n) ##[1:3] $fell(link_o.ss_n));
endmodule : sbc_core_checker

bind sbc_core sbc_core_checker u_checker (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
    .wb_rsp_o(wb_rsp_o), .link_i(link_i), .link_o(link_o));

//--- verification/sbc_slave_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// serial slave at the far end of the link, mode 0, msb first
// ----------------------------------------------------------------------------
module sbc_slave_model (
    // link from the master, answer byte from the bench
    input wire logic sck_i,
    input wire logic ss_n_i,
    input wire logic mosi_i,
    input wire logic [7:0] rsp_i,
    // answer and capture report
    output logic miso_o,
    output logic [7:0] rx_o,
    output logic rx_stb_o
);
    logic [7:0] sh_reg = 8'h00;
    logic [7:0] in_reg = 8'h00;
    int n = 0;
    initial begin
        miso_o = 1'b0;
        rx_o = 8'h00;
        rx_stb_o = 1'b0;
    end
    // load answer on select
    always @(negedge ss_n_i) begin
        sh_reg = rsp_i;
        n = 0;
        miso_o = rsp_i[7];
    end
    always @(posedge ss_n_i) miso_o = ~miso_o; // released line must not keep its last bit
    // capture on rising clock
    always @(posedge sck_i) if (!ss_n_i) begin
        in_reg = {in_reg[6:0], mosi_i};
        n = n + 1;
        if (n == 8) begin
            rx_o = in_reg;
            rx_stb_o = 1'b1;
            #1 rx_stb_o = 1'b0;
        end
    end
    // shift out on falling clock
    always @(negedge sck_i) if (!ss_n_i) begin
        sh_reg = {sh_reg[6:0], 1'b0};
        miso_o = sh_reg[7];
    end
endmodule : sbc_slave_model

//--- verification/sbc_core_test.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// self-checking bench for the serial core in master mode
// ----------------------------------------------------------------------------
module sbc_core_test
    import sbc_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    sbc_wb_req_s wb_req_i = '0;
    sbc_wb_rsp_s wb_rsp_o;
    sbc_link_in_s link_i;
    sbc_link_out_s link_o;
    logic slave_miso;
    logic [7:0] rsp_byte = 8'h00;
    logic [7:0] rx_byte;
    logic rx_stb;
    logic [31:0] rd_data;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [7:0] mosi_q[$];
    integer seed = 32'hf454;
    int fail_count = 0;
    int cmp_count = 0;
    always #5 clk_i = ~clk_i;
    // slave inputs idle; far side answers on miso
    assign link_i = {1'b0, 1'b0, slave_miso, 1'b1};
    sbc_core DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
        .wb_rsp_o(wb_rsp_o), .link_i(link_i), .link_o(link_o));
    sbc_slave_model u_slave (.sck_i(link_o.sck & link_o.sck_oe), .ss_n_i(link_o.ss_n),
        .mosi_i(link_o.mosi & link_o.mosi_oe), .rsp_i(rsp_byte), .miso_o(slave_miso), .rx_o(rx_byte),
        .rx_stb_o(rx_stb));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    // one classic cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int t;
        t = 0;
        wb_req_i <= {1'b1, 1'b1, we, adr, 4'h1, dat};
        do begin
            @(posedge clk_i);
            t++;
        end while (wb_rsp_o.ack !== 1'b1 && t < 400);
        rd_data = wb_rsp_o.dat;
        wb_req_i <= '0;
        @(posedge clk_i);
        check(32'(t < 400), 32'h1, "bus answer");
    endtask : wb
    task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] msk);
        exp_q.push_back(exp & msk);
        msk_q.push_back(msk);
        wb(1'b0, adr, 32'h0);
    endtask : rd
    task automatic poll(input int pos, input logic val);
        int t;
        t = 0;
        do begin
            rd(ADR_STAT, 32'h0, 32'h0);
            t++;
        end while (rd_data[pos] !== val && t < 2000);
        check(32'(t < 2000), 32'h1, "status wait");
    endtask : poll
    task automatic send(input logic [7:0] d, input logic [7:0] r);
        rsp_byte <= r;
        mosi_q.push_back(d);
        wb(1'b1, ADR_DATA, {24'h0, d});
    endtask : send
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        for (int i = 7; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h1d : 8'h00);
        return c;
    endfunction : crc8
    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    // reads against the oldest note
    always @(posedge clk_i) begin
        if (wb_rsp_o.ack === 1'b1 && wb_req_i.we === 1'b0 && exp_q.size() > 0) begin
            check(wb_rsp_o.dat & msk_q.pop_front(), exp_q.pop_front(), "read data");
        end
    end
    // bytes seen by the far side
    always @(posedge rx_stb) begin
        if (mosi_q.size() > 0) check({24'h0, rx_byte}, {24'h0, mosi_q.pop_front()}, "sent byte");
        else check(32'h1, 32'h0, "surplus frame");
    end
    // watchdog well beyond the expected run
    initial begin
        #300000;
        check(32'h1, 32'h0, "run time");
        tally_and_finish();
    end
    initial begin
        logic [7:0] d, r, tc, rc;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // reset values, read-only, unmapped
        rd(ADR_STAT, 32'h22, 32'h3f);
        rd(ADR_CTRL, 32'h0400, 32'hffff);
        rd(ADR_POLY, 32'h07, 32'hff);
        wb(1'b1, ADR_TXCRC, 32'hff);
        rd(ADR_TXCRC, 32'h0, 32'hff);
        wb(1'b1, 8'h20, 32'hff);
        rd(8'h20, 32'h0, 32'hffffffff);
        $display("test reset done");
        // single frames with random data
        wb(1'b1, ADR_CTRL, 32'h3);
        for (int i = 0; i < 4; i++) begin
            d = $random(seed);
            r = $random(seed);
            send(d, r);
            poll(STAT_RECEIVE_NOT_EMPTY_EVENT, 1'b1);
            rd(ADR_STAT, 32'h06, 32'h07);
            rd(ADR_DATA, {24'h0, r}, 32'hff);
            rd(ADR_STAT, 32'h02, 32'h07);
        end
        $display("test frames done");
        // disable during the last frame
        send(8'ha5, 8'h3c);
        rd(ADR_STAT, 32'h01, 32'h03);
        poll(STAT_TXE, 1'b1);
        rd(ADR_STAT, 32'h01, 32'h01);
        wb(1'b1, ADR_CTRL, 32'h2);
        poll(STAT_BUSY, 1'b0);
        rd(ADR_STAT, 32'h06, 32'h07);
        rd(ADR_DATA, 32'h3c, 32'hff);
        $display("test disable done");
        // fill while disabled, then drain
        for (int i = 0; i < FIFO_DEPTH; i++) send(8'($random(seed)), 8'h5a);
        rd(ADR_STAT, 32'h10, 32'h30);
        wb(1'b1, ADR_CTRL, 32'h3);
        poll(STAT_EMPTY, 1'b1);
        poll(STAT_BUSY, 1'b0);
        rd(ADR_DATA, 32'h5a, 32'hff);
        $display("test fifo done");
        // crc good, then corrupted
        wb(1'b1, ADR_POLY, 32'h1d);
        rd(ADR_POLY, 32'h1d, 32'hff);
        wb(1'b1, ADR_CTRL, 32'h7);
        for (int k = 0; k < 2; k++) begin
            tc = 8'h00;
            rc = 8'h00;
            for (int i = 0; i < 3; i++) begin
                d = $random(seed);
                r = $random(seed);
                tc = crc8(tc, d);
                rc = crc8(rc, r);
                send(d, r);
                poll(STAT_RECEIVE_NOT_EMPTY_EVENT, 1'b1);
                rd(ADR_DATA, {24'h0, r}, 32'hff);
            end
            rd(ADR_TXCRC, {24'h0, tc}, 32'hff);
            rsp_byte <= rc ^ 8'(k);
            mosi_q.push_back(tc);
            wb(1'b1, ADR_CTRL, 32'hf);
            poll(STAT_RECEIVE_NOT_EMPTY_EVENT, 1'b1);
            rd(ADR_STAT, 32'h2 | (32'(k) << 3), 32'hb);
            rd(ADR_DATA, {24'h0, rc ^ 8'(k)}, 32'hff);
            wb(1'b1, ADR_STAT, 32'h8);
            rd(ADR_STAT, 32'h0, 32'h8);
        end
        $display("test crc done");
        check(32'(mosi_q.size()), 32'h0, "frames missing");
        tally_and_finish();
    end
endmodule : sbc_core_test
